// File: rtl/rfsc_axil_port.sv
`timescale 1ns/100ps
module rfsc_axil_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_wr_en,
  output logic [3:0]       o_wr_addr,
  output logic [7:0]       o_wr_data,
  input  wire logic        i_wr_ok,
  output logic             o_rd_en,
  output logic [3:0]       o_rd_addr,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic        i_rd_ok
);
  import rfsc_pkg::*;

  typedef struct packed {
    logic        aw_held;
    logic [3:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } rfsc_axi_t;

  rfsc_axi_t st;
  rfsc_axi_t next_st;
  logic      do_write;
  logic      do_read;

  assign o_awready = !st.aw_held && !st.bvalid;
  assign o_wready  = !st.w_held && !st.bvalid;
  assign o_arready = !st.rvalid;
  assign do_write  = st.aw_held && st.w_held && !st.bvalid;
  assign do_read   = i_arvalid && !st.rvalid;
  assign o_wr_en   = do_write && st.w_lane0;
  assign o_wr_addr = st.aw_addr;
  assign o_wr_data = st.w_data;
  assign o_rd_en   = do_read;
  assign o_rd_addr = i_araddr;

  always_comb begin
    next_st = st;
    if (i_awvalid && o_awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = i_wdata[7:0];
      next_st.w_lane0 = i_wstrb[0];
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = i_wr_ok ? 2'h0 : 2'h2;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = i_rd_data;
      next_st.rresp  = i_rd_ok ? 2'h0 : 2'h2;
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_bvalid = st.bvalid;
  assign o_bresp  = st.bresp;
  assign o_rvalid = st.rvalid;
  assign o_rresp  = st.rresp;
  assign o_rdata  = {24'h000000, st.rdata};
endmodule

// File: rtl/rfsc_config_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - auto-discard bit set: drop last received packet when its crc failed
// R2 - host must flush the receive queue before setting auto-discard again
// R3 - one 7-bit threshold serves both queues, counted in opposite directions
// R4 - threshold 0: tx 127 / rx 1 byte; 127: tx 0 / rx 128 bytes
// R5 - 8-bit filter address, reset zero, filters received packets
// R6 - policy 00: calibrate only on the explicit calibrate command
// R7 - policy 01: calibrate on idle to receive, transmit or synth-on entry
// R8 - policy 10: calibrate on every automatic return to idle
// R9 - policy 11: calibrate on every fourth automatic return to idle
// R10 - settle field picks lock wait 50/20, 75/30, 100/40 or 150/60 us
// R11 - bit 0 picks regulator wait, 30 us clear, 60 us set
// R12 - out-of-lock detector enable, off after reset
// R13 - band field picks lo divider 4..24; other codes unused
// R14 - upper bits 7:5 of settling and synth registers read zero
module rfsc_config_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_pkt_done,
  input  wire logic        i_pkt_crc_err,
  input  wire logic [7:0]  i_pkt_dest_addr,
  input  wire logic [7:0]  i_rx_level,
  input  wire logic [7:0]  i_tx_level,
  input  wire logic        i_idle_to_active,
  input  wire logic        i_auto_return_idle,
  input  wire logic        i_calibrate_cmd,
  input  wire logic        i_rx_flush_cmd,
  input  wire logic        i_switch_rxtx,
  output logic             o_discard_last_pkt,
  output logic             o_addr_match,
  output logic             o_rx_thr_reached,
  output logic             o_tx_thr_reached,
  output logic             o_calibrate,
  output logic             o_lock_wait_busy,
  output logic             o_regulator_wait_busy,
  output logic             o_lock_loss_detector_on,
  output logic [4:0]       o_lo_divider,
  output logic             o_lo_divider_band_valid
);
  import rfsc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] queue_config;
    logic [7:0] packet_filter_address;
    logic [7:0] synth_settling_config;
    logic [7:0] synth_config;
    logic [1:0] return_count;
    logic       discard;
    logic       match;
    logic       calibrate;
    logic       reg_start;
    logic [4:0] divider;
    logic       band_ok;
  } rfsc_regs_t;

  rfsc_regs_t st;
  rfsc_regs_t next_st;

  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_ok;
  logic [3:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        rd_ok;
  logic        lock_start;
  logic [12:0] lock_cycles;
  logic [12:0] reg_cycles;
  logic [6:0]  thr;
  logic [1:0]  policy;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] us_to_cycles(input int us);
    us_to_cycles = 13'(us) * CYC_PER_US;
  endfunction

  function automatic logic [4:0] band_divider(input logic [3:0] band);
    case (band)
      4'h2:    band_divider = 5'h04;
      4'h4:    band_divider = 5'h08;
      4'h6:    band_divider = 5'h0c;
      4'h8:    band_divider = 5'h10;
      4'ha:    band_divider = 5'h14;
      4'hb:    band_divider = 5'h18;
      default: band_divider = 5'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  rfsc_axil_port u_axil (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .i_wr_ok   (wr_ok),
    .o_rd_en   (),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );

  assign wr_ok = (wr_addr[1:0] == 2'h0);
  assign rd_ok = (rd_addr[1:0] == 2'h0);

  always_comb begin
    case (rd_addr)
      ADDR_QUEUE_CONFIG:    rd_data = st.queue_config;
      ADDR_FILTER_ADDRESS:  rd_data = st.packet_filter_address;
      ADDR_SETTLING_CONFIG: rd_data = st.synth_settling_config & MASK_SETTLING; // see R14
      ADDR_SYNTH_CONFIG:    rd_data = st.synth_config & MASK_SYNTH; // see R14
      default:              rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // queue thresholds
  // ---------------------------------------------------------------
  assign thr = st.queue_config[6:0];
  // see R3
  assign o_tx_thr_reached = (i_tx_level <= (8'h7f - {1'b0, thr})); // see R4
  assign o_rx_thr_reached = (i_rx_level >= ({1'b0, thr} + 8'h01)); // see R4

  // ---------------------------------------------------------------
  // synthesizer waits
  // ---------------------------------------------------------------
  assign policy = st.synth_settling_config[4:3];

  always_comb begin
    case (st.synth_settling_config[2:1])
      2'h0:    lock_cycles = i_switch_rxtx ? us_to_cycles(LOCK_SW_US0)
                                           : us_to_cycles(LOCK_CAL_US0); // see R10
      2'h1:    lock_cycles = i_switch_rxtx ? us_to_cycles(LOCK_SW_US1)
                                           : us_to_cycles(LOCK_CAL_US1);
      2'h2:    lock_cycles = i_switch_rxtx ? us_to_cycles(LOCK_SW_US2)
                                           : us_to_cycles(LOCK_CAL_US2);
      default: lock_cycles = i_switch_rxtx ? us_to_cycles(LOCK_SW_US3)
                                           : us_to_cycles(LOCK_CAL_US3);
    endcase
  end

  assign reg_cycles = st.synth_settling_config[0] ? us_to_cycles(REG_SETTLE_US1)
                                                  : us_to_cycles(REG_SETTLE_US0); // see R11
  assign lock_start = st.calibrate || i_switch_rxtx;

  rfsc_wait_timer u_lock_wait (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (lock_start),
    .i_cycles  (lock_cycles),
    .o_busy    (o_lock_wait_busy),
    .o_done    ()
  );

  rfsc_wait_timer u_reg_wait (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (st.reg_start),
    .i_cycles  (reg_cycles),
    .o_busy    (o_regulator_wait_busy),
    .o_done    ()
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.discard   = 1'b0;
    next_st.calibrate = 1'b0;
    next_st.reg_start = 1'b0;
    if (wr_en) begin
      case (wr_addr)
        ADDR_QUEUE_CONFIG:    next_st.queue_config = wr_data;
        ADDR_FILTER_ADDRESS:  next_st.packet_filter_address = wr_data; // see R5
        ADDR_SETTLING_CONFIG: next_st.synth_settling_config = wr_data & MASK_SETTLING; // see R14
        ADDR_SYNTH_CONFIG:    next_st.synth_config = wr_data & MASK_SYNTH; // see R14
        default:              next_st.queue_config = st.queue_config;
      endcase
    end
    // see R1
    if (i_pkt_done && i_pkt_crc_err && st.queue_config[POS_AUTO_DISCARD]) begin
      next_st.discard = 1'b1;
    end
    // see R5
    if (i_pkt_done) begin
      next_st.match = (i_pkt_dest_addr == st.packet_filter_address);
    end
    if (i_calibrate_cmd) begin
      next_st.calibrate = 1'b1; // see R6
    end
    case (policy)
      CAL_ON_START: begin
        if (i_idle_to_active) begin
          next_st.calibrate = 1'b1; // see R7
        end
      end
      CAL_ON_RETURN: begin
        if (i_auto_return_idle) begin
          next_st.calibrate = 1'b1; // see R8
        end
      end
      CAL_EVERY_4TH: begin
        if (i_auto_return_idle) begin
          next_st.return_count = st.return_count + 2'h1; // see R9
          if (st.return_count == RETURN_CNT_TOP) begin
            next_st.calibrate = 1'b1; // see R9
          end
        end
      end
      default: next_st.return_count = st.return_count; // see R6
    endcase
    if (i_idle_to_active) begin
      next_st.reg_start = 1'b1; // see R11
    end
    next_st.divider = band_divider(st.synth_config[3:0]); // see R13
    next_st.band_ok = (band_divider(st.synth_config[3:0]) != 5'h00); // see R13
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st                       <= '0;
      st.queue_config          <= RST_QUEUE_CONFIG;
      st.packet_filter_address <= RST_FILTER_ADDRESS;
      st.synth_settling_config <= RST_SETTLING_CONFIG;
      st.synth_config          <= RST_SYNTH_CONFIG;
      st.divider               <= RST_LO_DIVIDER;
      st.band_ok               <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_discard_last_pkt      = st.discard;
  assign o_addr_match            = st.match;
  assign o_calibrate             = st.calibrate;
  assign o_lock_loss_detector_on = st.synth_config[POS_LOCK_DETECT]; // see R12
  assign o_lo_divider            = st.divider;
  assign o_lo_divider_band_valid = st.band_ok;
endmodule

// File: rtl/rfsc_pkg.sv
package rfsc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_QUEUE_CONFIG    = 4'h0;
  localparam logic [3:0] ADDR_FILTER_ADDRESS  = 4'h4;
  localparam logic [3:0] ADDR_SETTLING_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_SYNTH_CONFIG    = 4'hc;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_QUEUE_CONFIG    = 8'h80;
  localparam logic [7:0] RST_FILTER_ADDRESS  = 8'h00;
  localparam logic [7:0] RST_SETTLING_CONFIG = 8'h0b;
  localparam logic [7:0] RST_SYNTH_CONFIG    = 8'h02;
  localparam logic [4:0] RST_LO_DIVIDER      = 5'h04;
  localparam int         POS_AUTO_DISCARD    = 7;
  localparam int         POS_LOCK_DETECT     = 4;
  localparam logic [7:0] MASK_SETTLING       = 8'h1f;
  localparam logic [7:0] MASK_SYNTH          = 8'h1f;

  // ---------------------------------------------------------------
  // calibration policy codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CAL_NEVER      = 2'h0;
  localparam logic [1:0] CAL_ON_START   = 2'h1;
  localparam logic [1:0] CAL_ON_RETURN  = 2'h2;
  localparam logic [1:0] CAL_EVERY_4TH  = 2'h3;
  localparam logic [1:0] RETURN_CNT_TOP = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int LOCK_CAL_US0   = 50;
  localparam int LOCK_CAL_US1   = 75;
  localparam int LOCK_CAL_US2   = 100;
  localparam int LOCK_CAL_US3   = 150;
  localparam int LOCK_SW_US0    = 20;
  localparam int LOCK_SW_US1    = 30;
  localparam int LOCK_SW_US2    = 40;
  localparam int LOCK_SW_US3    = 60;
  localparam int REG_SETTLE_US0 = 30;
  localparam int REG_SETTLE_US1 = 60;
  localparam logic [12:0] CYC_PER_US = 13'(CLK_MHZ);
endpackage

// File: rtl/rfsc_wait_timer.sv
`timescale 1ns/100ps
module rfsc_wait_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [12:0] i_cycles,
  output logic             o_busy,
  output logic             o_done
);
  import rfsc_pkg::*;

  typedef struct packed {
    logic [12:0] count;
    logic        busy;
    logic        done;
  } rfsc_tmr_t;

  rfsc_tmr_t st;
  rfsc_tmr_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (i_start) begin
      next_st.count = i_cycles;
      next_st.busy  = 1'b1;
    end else if (st.busy) begin
      if (st.count <= 13'h0001) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count - 13'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;
endmodule

// File: tb/radio_fifo_synth_config_regs_test.sv
`timescale 1ns/100ps
module radio_fifo_synth_config_regs_test;
  import rfsc_pkg::*;
  // ------
  // signals
  // ------
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, i_pkt_crc_err = 1'b0;
  logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
  logic [31:0] i_wdata = 32'h0;
  logic [7:0]  i_pkt_dest_addr = 8'h0, i_rx_level = 8'h0, i_tx_level = 8'h0;
  logic [5:0]  ev = 6'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_discard_last_pkt;
  logic        o_addr_match, o_rx_thr_reached, o_tx_thr_reached, o_calibrate;
  logic        o_lock_wait_busy, o_regulator_wait_busy, o_lock_loss_detector_on;
  logic        o_lo_divider_band_valid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [4:0]  o_lo_divider;
  int          bad_count = 0, n_checks = 0, cycles = 0, cal_seen = 0, n, e;
  int          dv[12] = '{0, 0, 4, 0, 8, 0, 12, 0, 16, 0, 20, 24};
  int          sw_us[4] = '{20, 30, 40, 60};
  int          cal_us[4] = '{50, 75, 100, 150};
  int          th[6][5] = '{'{0, 127, 1, 1, 1}, '{0, 128, 0, 0, 0}, '{127, 0, 128, 1, 1},
                            '{127, 1, 127, 0, 0}, '{64, 63, 65, 1, 1}, '{64, 64, 64, 0, 0}};
  int          pk[4][5] = '{'{1, 1, 8'h5a, 1, 1}, '{1, 0, 8'h5b, 0, 0}, '{0, 1, 8'h5a, 0, 1},
                            '{1, 1, 8'h00, 1, 0}};

  rfsc_config_regs DUT (
    .i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_pkt_done(ev[4]), .i_pkt_crc_err, .i_pkt_dest_addr,
    .i_rx_level, .i_tx_level, .i_idle_to_active(ev[0]), .i_auto_return_idle(ev[1]),
    .i_calibrate_cmd(ev[2]), .i_rx_flush_cmd(ev[5]), .i_switch_rxtx(ev[3]),
    .o_discard_last_pkt, .o_addr_match, .o_rx_thr_reached, .o_tx_thr_reached, .o_calibrate,
    .o_lock_wait_busy, .o_regulator_wait_busy, .o_lock_loss_detector_on, .o_lo_divider,
    .o_lo_divider_band_valid
  );

  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // ------
  // tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = 2'h0);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int g = 0; g < 100 && !b_t; g++) begin
      @(negedge i_sys_clk);
      aw_t = i_awvalid && (o_awready === 1'b1);
      w_t = i_wvalid && (o_wready === 1'b1);
      b_t = (o_bvalid === 1'b1);
      r = o_bresp;
      @(posedge i_sys_clk);
      if (aw_t) i_awvalid <= 1'b0;
      if (w_t) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    check("write done", b_t, 1'b1);
    check("write resp", r, er);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] ex);
    logic ar_t, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'b0;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int g = 0; g < 100 && !v; g++) begin
      @(negedge i_sys_clk);
      ar_t = i_arvalid && (o_arready === 1'b1);
      v = (o_rvalid === 1'b1);
      d = o_rdata;
      r = o_rresp;
      @(posedge i_sys_clk);
      if (ar_t) i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    check("read done", v, 1'b1);
    check("read data", d, {24'h0, ex});
    check("read resp", r, 2'h0);
  endtask
  task automatic ev_set(input logic [5:0] m);
    @(posedge i_sys_clk);
    ev <= m;
  endtask
  task automatic wait_idle();
    for (int g = 0; g < 5000 && (o_lock_wait_busy !== 1'b0 || o_regulator_wait_busy !== 1'b0);
         g++) @(negedge i_sys_clk);
  endtask
  task automatic busy_len(input logic sel, output int len);
    logic b;
    len = 0;
    for (int g = 0; g < 5000; g++) begin
      @(negedge i_sys_clk);
      b = sel ? o_regulator_wait_busy : o_lock_wait_busy;
      if (b === 1'b1) len++;
      else if (len > 0) break;
    end
  endtask
  // ------
  // event pulses last one cycle; watchdog
  // ------
  always @(posedge i_sys_clk) begin
    if (ev != 6'h0) ev <= 6'h0;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  always @(negedge i_sys_clk) if (o_calibrate === 1'b1) cal_seen++;
  // ------
  // tests
  // ------
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rdchk(ADDR_QUEUE_CONFIG, 8'h80);
    rdchk(ADDR_FILTER_ADDRESS, 8'h00);
    rdchk(ADDR_SETTLING_CONFIG, 8'h0b);
    rdchk(ADDR_SYNTH_CONFIG, 8'h02);
    check("lock detector", o_lock_loss_detector_on, 1'b0);
    check("divider", o_lo_divider, 5'h04);
    wr(ADDR_SETTLING_CONFIG, 8'hff);
    rdchk(ADDR_SETTLING_CONFIG, 8'h1f);
    wr(ADDR_SYNTH_CONFIG, 8'hff);
    rdchk(ADDR_SYNTH_CONFIG, 8'h1f);
    check("lock detector", o_lock_loss_detector_on, 1'b1);
    for (int k = 0; k < 12; k++) begin
      wr(ADDR_SYNTH_CONFIG, 8'(k));
      repeat (2) @(negedge i_sys_clk);
      check("divider", o_lo_divider, dv[k]);
      check("band valid", o_lo_divider_band_valid, dv[k] != 0);
      check("lock detector", o_lock_loss_detector_on, 1'b0);
    end
    wr(4'h1, 8'h55, 4'hf, 2'h2);
    rdchk(ADDR_QUEUE_CONFIG, 8'h80);
    wr(ADDR_FILTER_ADDRESS, 8'h33, 4'he);
    rdchk(ADDR_FILTER_ADDRESS, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_QUEUE_CONFIG, {1'b1, 7'(th[k][0])});
      @(posedge i_sys_clk);
      i_tx_level <= 8'(th[k][1]);
      i_rx_level <= 8'(th[k][2]);
      @(negedge i_sys_clk);
      check("tx threshold", o_tx_thr_reached, th[k][3]);
      check("rx threshold", o_rx_thr_reached, th[k][4]);
    end
    wr(ADDR_FILTER_ADDRESS, 8'h5a);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) ev_set(6'h20); // flush before re-enabling discard
      wr(ADDR_QUEUE_CONFIG, {1'(pk[k][0]), 7'h0});
      ev_set(6'h10);
      i_pkt_crc_err <= 1'(pk[k][1]);
      i_pkt_dest_addr <= 8'(pk[k][2]);
      repeat (2) @(negedge i_sys_clk);
      check("discard", o_discard_last_pkt, pk[k][3]);
      check("address match", o_addr_match, pk[k][4]);
    end
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_SETTLING_CONFIG, {3'h0, 2'(p), 3'h3});
      cal_seen = 0;
      ev_set(6'h01);
      repeat (3) @(negedge i_sys_clk);
      e = (p == 1);
      check("cal on start", cal_seen, e);
      for (int j = 0; j < 4; j++) begin
        ev_set(6'h02);
        repeat (3) @(negedge i_sys_clk);
      end
      e = e + (p == 2) * 4 + (p == 3);
      check("cal on return", cal_seen, e);
      ev_set(6'h04);
      repeat (3) @(negedge i_sys_clk);
      check("cal on command", cal_seen, e + 1);
    end
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SETTLING_CONFIG, {5'h0, 2'(k), 1'b1});
      wait_idle();
      ev_set(6'h08);
      busy_len(1'b0, n);
      check("switch wait", n, sw_us[k] * CLK_MHZ);
      ev_set(6'h04);
      busy_len(1'b0, n);
      check("cal wait", n, cal_us[k] * CLK_MHZ);
    end
    for (int b = 0; b < 2; b++) begin
      wr(ADDR_SETTLING_CONFIG, {7'h0, 1'(b)});
      wait_idle();
      ev_set(6'h01);
      busy_len(1'b1, n);
      check("regulator wait", n, (b ? 60 : 30) * CLK_MHZ);
    end
    stop_test();
  end
endmodule

bind rfsc_config_regs rfsc_checker chk (
  .i_sys_clk, .i_rst_n, .i_arvalid, .o_arready, .o_rvalid, .o_awready, .o_wready, .o_bvalid,
  .i_pkt_done, .i_pkt_crc_err, .o_discard_last_pkt, .i_idle_to_active, .i_auto_return_idle,
  .i_calibrate_cmd, .i_switch_rxtx, .o_calibrate, .o_lock_wait_busy, .o_regulator_wait_busy
);

// File: tb/rfsc_checker.sv
`timescale 1ns/100ps
module rfsc_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_pkt_done,
  input wire logic i_pkt_crc_err,
  input wire logic o_discard_last_pkt,
  input wire logic i_idle_to_active,
  input wire logic i_auto_return_idle,
  input wire logic i_calibrate_cmd,
  input wire logic i_switch_rxtx,
  input wire logic o_calibrate,
  input wire logic o_lock_wait_busy,
  input wire logic o_regulator_wait_busy
);
  // ------
  // length of the running lock wait
  // ------
  logic [12:0] busy_run;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_run <= 13'h0;
    end else begin
      busy_run <= o_lock_wait_busy ? busy_run + 13'h1 : 13'h0;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence sw_start;
    i_switch_rxtx ##1 o_lock_wait_busy;
  endsequence
  lock_hold_a: assert property (sw_start |-> o_lock_wait_busy [*8])
    else $error("lock wait dropped early");
  lock_bound_a: assert property (busy_run <= 13'hea6)
    else $error("lock wait too long");
  discard_cause_a: assert property (o_discard_last_pkt |->
    $past(i_pkt_done && i_pkt_crc_err))
    else $error("discard without crc failure");
  cal_cmd_a: assert property (i_calibrate_cmd |=> o_calibrate)
    else $error("calibrate command ignored");
  cal_cause_a: assert property (o_calibrate |->
    $past(i_calibrate_cmd || i_idle_to_active || i_auto_return_idle))
    else $error("calibration without cause");
  reg_start_a: assert property (i_idle_to_active |-> ##[1:2] o_regulator_wait_busy)
    else $error("regulator wait not started");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while answer pending");
  aw_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
endmodule
